// ===== hdl/mmr_consts.svh
`ifndef MMR_CONSTS_SVH
`define MMR_CONSTS_SVH

// ----------------------------------------
// answer codes
// ----------------------------------------
`define MMR_EXC_NONE 8'h00
`define MMR_EXC_ADDR 8'h02
`define MMR_EXC_FAIL 8'h04

// ----------------------------------------
// signature register
// ----------------------------------------
`define MMR_SIG_RST  16'h0000
`define MMR_SIG_STEP 16'h0001
`define MMR_SIG_SLOT 5'h00

// ----------------------------------------
// measured value index nibble
// ----------------------------------------
`define MMR_MV_MIN 4'h1
`define MMR_MV_MAX 4'h8

// ----------------------------------------
// range table: lo, hi, per-value, ifaces (gw,tcp,rtu), gated, writable
// ----------------------------------------
`define MMR_RNG_N 16
`define MMR_RNG_W 38
`define MMR_RNG_00 {16'h0000, 16'h0068, 1'h0, 3'h7, 1'h0, 1'h0}
`define MMR_RNG_01 {16'h0080, 16'h00AA, 1'h0, 3'h5, 1'h0, 1'h0}
`define MMR_RNG_02 {16'h0200, 16'h0208, 1'h0, 3'h7, 1'h0, 1'h0}
`define MMR_RNG_03 {16'h0300, 16'h0301, 1'h0, 3'h7, 1'h0, 1'h1}
`define MMR_RNG_04 {16'h0302, 16'h0309, 1'h0, 3'h7, 1'h1, 1'h1}
`define MMR_RNG_05 {16'h0000, 16'h0014, 1'h1, 3'h7, 1'h0, 1'h0}
`define MMR_RNG_06 {16'h0100, 16'h0122, 1'h1, 3'h7, 1'h1, 1'h1}
`define MMR_RNG_07 {16'h0200, 16'h0210, 1'h1, 3'h7, 1'h0, 1'h0}
`define MMR_RNG_08 {16'h0300, 16'h0328, 1'h1, 3'h7, 1'h0, 1'h0}
`define MMR_RNG_09 {16'h0340, 16'h034A, 1'h1, 3'h5, 1'h0, 1'h0}
`define MMR_RNG_10 {16'h0400, 16'h0408, 1'h1, 3'h7, 1'h0, 1'h0}
`define MMR_RNG_11 {16'h0500, 16'h0501, 1'h1, 3'h7, 1'h0, 1'h1}
`define MMR_RNG_12 {16'h0502, 16'h0503, 1'h1, 3'h7, 1'h1, 1'h1}
`define MMR_RNG_13 {16'hA000, 16'hA016, 1'h0, 3'h4, 1'h0, 1'h0}
`define MMR_RNG_14 {16'hA100, 16'hA104, 1'h0, 3'h7, 1'h0, 1'h1}
`define MMR_RNG_15 {16'hA105, 16'hA111, 1'h0, 3'h7, 1'h1, 1'h1}

`endif

// ===== hdl/mmr_pkg.sv
package mmr_pkg;

    // ----------------------------------------
    // requesting interface
    // ----------------------------------------
    typedef enum logic [1:0] {
        MMR_IF_RTU = 2'h0,
        MMR_IF_TCP = 2'h1,
        MMR_IF_GW  = 2'h2
    } mmr_iface_t;

    // ----------------------------------------
    // value formats offered by the application
    // ----------------------------------------
    typedef enum logic [2:0] {
        MMR_FMT_U8PAIR = 3'h0,
        MMR_FMT_U16    = 3'h1,
        MMR_FMT_U32    = 3'h2,
        MMR_FMT_F32    = 3'h3,
        MMR_FMT_UTF8   = 3'h4,
        MMR_FMT_ASCII  = 3'h5
    } mmr_fmt_t;

    // ----------------------------------------
    // request sequencer
    // ----------------------------------------
    typedef enum logic [1:0] {
        MMR_ST_IDLE = 2'h0,
        MMR_ST_APP  = 2'h1
    } mmr_state_t;

    typedef struct packed {
        mmr_state_t  state;
        logic [15:0] sig;
        logic        write;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        rd_req;
        logic        wr_req;
        logic        rsp_valid;
        logic [15:0] rdata;
        logic [7:0]  exc;
    } mmr_top_t;

endpackage

// ===== hdl/mmr_range_dec.sv
`timescale 1ns/1ps
`include "mmr_consts.svh"

module mmr_range_dec (
    input  wire logic [15:0] i_addr,
    input  wire logic [1:0]  i_iface,
    output logic             o_allowed,
    output logic             o_writable,
    output logic             o_gated
);

    // ----------------------------------------
    // range table, entry 0 in the low bits
    // ----------------------------------------
    localparam logic [`MMR_RNG_N*`MMR_RNG_W-1:0] TBL = {
        `MMR_RNG_15, `MMR_RNG_14, `MMR_RNG_13, `MMR_RNG_12,
        `MMR_RNG_11, `MMR_RNG_10, `MMR_RNG_09, `MMR_RNG_08,
        `MMR_RNG_07, `MMR_RNG_06, `MMR_RNG_05, `MMR_RNG_04,
        `MMR_RNG_03, `MMR_RNG_02, `MMR_RNG_01, `MMR_RNG_00
    };

    logic [`MMR_RNG_N-1:0] allow_v;  // hit and reachable
    logic [`MMR_RNG_N-1:0] wr_v;     // hit and writable
    logic [`MMR_RNG_N-1:0] gate_v;   // hit and login gated here
    logic                  mv_ok;    // upper nibble names a value
    logic                  is_gw;    // gateway link carried it

    // per-value blocks: nibble 1..8 selects the measured value
    assign mv_ok = (i_addr[15:12] >= `MMR_MV_MIN) && (i_addr[15:12] <= `MMR_MV_MAX);
    assign is_gw = (i_iface == mmr_pkg::MMR_IF_GW);

    // ----------------------------------------
    // one comparator set per range entry
    // ----------------------------------------
    for (genvar i = 0; i < `MMR_RNG_N; i++) begin : g_rng
        logic [`MMR_RNG_W-1:0] e;
        logic                  hit;
        assign e   = TBL[i*`MMR_RNG_W +: `MMR_RNG_W];
        // per-value entries compare only the low twelve bits
        // low twelve bits of lo sit at 33:22, of hi at 17:6
        assign hit = e[5] ? (mv_ok && i_addr[11:0] >= e[33:22] && i_addr[11:0] <= e[17:6])
                          : (i_addr >= e[37:22] && i_addr <= e[21:6]);
        // interface 3 is no interface: never reachable
        assign allow_v[i] = hit && (i_iface != 2'h3) && e[2 + i_iface];
        assign wr_v[i]    = hit && e[0];
        assign gate_v[i]  = hit && e[1] && is_gw;
    end

    // ranges do not overlap, so an or-reduction is exact
    assign o_allowed  = |allow_v;
    assign o_writable = |wr_v;
    assign o_gated    = |gate_v;

endmodule

// ===== hdl/mmr_word_pack.sv
`timescale 1ns/1ps

module mmr_word_pack (
    input  wire mmr_pkg::mmr_fmt_t i_fmt,
    input  wire logic [31:0]       i_word,
    input  wire logic              i_sel_hi,
    output logic [15:0]            o_reg
);

    logic       is_str;  // text format: termination applies
    logic [3:0] kill;    // byte lies after a zero terminator
    logic [31:0] txt;    // word with dead bytes cleared

    assign is_str = (i_fmt == mmr_pkg::MMR_FMT_UTF8) || (i_fmt == mmr_pkg::MMR_FMT_ASCII);
    assign kill[0] = 1'h0;

    // ----------------------------------------
    // text bytes: byte 0 first, dead after a zero
    // ----------------------------------------
    for (genvar i = 0; i < 4; i++) begin : g_byte
        if (i > 0) begin : g_kill
            assign kill[i] = kill[i-1] || (i_word[8*(i-1) +: 8] == 8'h00);
        end
        assign txt[8*i +: 8] = kill[i] ? 8'h00 : i_word[8*i +: 8];
    end

    // ----------------------------------------
    // pick the register half for the format
    // ----------------------------------------
    always_comb begin
        if (is_str) begin
            // first byte low, second byte high in each register
            o_reg = i_sel_hi ? txt[31:16] : txt[15:0];
        end else if (i_fmt == mmr_pkg::MMR_FMT_U32 || i_fmt == mmr_pkg::MMR_FMT_F32) begin
            // float keeps its sign bit at 31, same split as integers
            o_reg = i_sel_hi ? i_word[31:16] : i_word[15:0];
        end else begin
            // byte 1 at 15:8, byte 0 at 7:0; one register only
            o_reg = i_word[15:0];
        end
    end

endmodule

// ===== hdl/mmr_mapper.sv
`timescale 1ns/1ps
`include "mmr_consts.svh"

module mmr_mapper (
    input  wire logic        i_ref_clk,
    input  wire logic        i_arst_n,
    // register access from the protocol layer
    input  wire logic        i_req_valid,
    output logic             o_req_ready,
    input  wire logic        i_req_write,
    input  wire logic [15:0] i_req_addr,
    input  wire logic [15:0] i_req_wdata,
    input  wire logic [1:0]  i_req_iface,
    input  wire logic        i_login_ok,
    output logic             o_rsp_valid,
    output logic [15:0]      o_rsp_rdata,
    output logic [7:0]       o_rsp_exc,
    // application data behind the map
    output logic             o_app_rd_valid,
    output logic             o_app_wr_valid,
    output logic [15:0]      o_app_addr,
    output logic [15:0]      o_app_wdata,
    input  wire logic        i_app_ack,
    input  wire logic [31:0] i_app_rdata,
    input  wire logic [2:0]  i_app_fmt,
    input  wire logic        i_app_sel_hi,
    // current signature, for status
    output logic [15:0]      o_signature
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    mmr_pkg::mmr_top_t st_reg;   // all held state
    mmr_pkg::mmr_top_t st_next;  // its next value

    logic        fire;      // request taken this cycle
    logic        allowed;   // address reachable here
    logic        writable;  // address takes writes
    logic        gated;     // write needs a login here
    logic        sig_slot;  // address is a block's signature
    logic [15:0] pack_reg;  // application word as a register

    // ----------------------------------------
    // address decode and value packing
    // ----------------------------------------
    mmr_range_dec u_dec (
        .i_addr     (i_req_addr),
        .i_iface    (i_req_iface),
        .o_allowed  (allowed),
        .o_writable (writable),
        .o_gated    (gated)
    );

    // the application names the format of each word it returns
    mmr_word_pack u_pack (
        .i_fmt    (mmr_pkg::mmr_fmt_t'(i_app_fmt)),
        .i_word   (i_app_rdata),
        .i_sel_hi (i_app_sel_hi),
        .o_reg    (pack_reg)
    );

    // ----------------------------------------
    // handshake terms
    // ----------------------------------------
    // one request at a time: ready only while idle
    assign o_req_ready = (st_reg.state == mmr_pkg::MMR_ST_IDLE);
    assign fire        = i_req_valid && o_req_ready;

    // every allowed address on a 32-register boundary (low five bits zero) reads as the signature
    assign sig_slot = (i_req_addr[4:0] == `MMR_SIG_SLOT) && allowed;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_next           = st_reg;
        st_next.rsp_valid = 1'h0;
        case (st_reg.state)
            mmr_pkg::MMR_ST_IDLE: begin
                if (fire) begin
                    // keep the request for the application side
                    st_next.write = i_req_write;
                    st_next.addr  = i_req_addr;
                    st_next.wdata = i_req_wdata;
                    st_next.rdata = 16'h0000;
                    st_next.exc   = `MMR_EXC_NONE;
                    if (!allowed) begin
                        // unmapped or not on this link
                        st_next.rsp_valid = 1'h1;
                        st_next.exc       = `MMR_EXC_ADDR;
                    end else if (i_req_write && !writable && !sig_slot) begin
                        // read-only data refuses writes
                        st_next.rsp_valid = 1'h1;
                        st_next.exc       = `MMR_EXC_ADDR;
                    end else if (i_req_write && gated && !i_login_ok) begin
                        // gateway writes here need the login first
                        st_next.rsp_valid = 1'h1;
                        st_next.exc       = `MMR_EXC_FAIL;
                    end else if (sig_slot && i_req_write) begin
                        // store the new value; the answer carries zero data and the next read sees it
                        st_next.sig       = i_req_wdata;
                        st_next.rsp_valid = 1'h1;
                    end else if (sig_slot) begin
                        // any read of the slot decrements
                        st_next.rdata     = st_reg.sig;
                        st_next.sig       = 16'(st_reg.sig - `MMR_SIG_STEP);
                        st_next.rsp_valid = 1'h1;
                    end else if (i_req_write) begin
                        // acknowledgement, states, settings, login
                        st_next.wr_req = 1'h1;
                        st_next.state  = mmr_pkg::MMR_ST_APP;
                    end else begin
                        // fetch the word behind the address
                        st_next.rd_req = 1'h1;
                        st_next.state  = mmr_pkg::MMR_ST_APP;
                    end
                end
            end
            mmr_pkg::MMR_ST_APP: begin
                // wait as long as the application needs
                if (i_app_ack) begin
                    st_next.rd_req    = 1'h0;
                    st_next.wr_req    = 1'h0;
                    st_next.rsp_valid = 1'h1;
                    // writes answer with zero data
                    if (!st_reg.write) begin
                        st_next.rdata = pack_reg;
                    end
                    st_next.state = mmr_pkg::MMR_ST_IDLE;
                end
            end
            default: begin
                // unused code: return to idle
                st_next.state  = mmr_pkg::MMR_ST_IDLE;
                st_next.rd_req = 1'h0;
                st_next.wr_req = 1'h0;
            end
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_reg.state     <= mmr_pkg::MMR_ST_IDLE;
            st_reg.sig       <= `MMR_SIG_RST;
            st_reg.write     <= 1'h0;
            st_reg.addr      <= 16'h0000;
            st_reg.wdata     <= 16'h0000;
            st_reg.rd_req    <= 1'h0;
            st_reg.wr_req    <= 1'h0;
            st_reg.rsp_valid <= 1'h0;
            st_reg.rdata     <= 16'h0000;
            st_reg.exc       <= `MMR_EXC_NONE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // outputs, all from flip-flops
    // ----------------------------------------
    assign o_rsp_valid    = st_reg.rsp_valid;
    assign o_rsp_rdata    = st_reg.rdata;
    assign o_rsp_exc      = st_reg.exc;
    assign o_app_rd_valid = st_reg.rd_req;
    assign o_app_wr_valid = st_reg.wr_req;
    assign o_app_addr     = st_reg.addr;
    assign o_app_wdata    = st_reg.wdata;
    assign o_signature    = st_reg.sig;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_arst_n);

    // a signature read hands out the old value, then steps down
    sig_read_dec_a : assert property (
        fire && allowed && sig_slot && !i_req_write
        |=> o_rsp_valid && o_rsp_rdata == $past(o_signature)
            && o_signature == 16'($past(o_signature) - 16'h0001))
        else $error("signature read did not decrement");

    // a written signature is what the next read returns
    sig_write_echo_a : assert property (
        fire && allowed && sig_slot && i_req_write && !(gated && !i_login_ok)
        |=> o_signature == $past(i_req_wdata) && o_rsp_exc == 8'h00)
        else $error("signature write not stored");

    // zero steps to all ones
    sig_wrap_a : assert property (
        fire && allowed && sig_slot && !i_req_write && o_signature == 16'h0000
        |=> o_signature == 16'hFFFF)
        else $error("signature did not wrap");

    // unreachable address answers at once with address error
    deny_answer_a : assert property (
        fire && !allowed
        |=> o_rsp_valid && o_rsp_exc == 8'h02 && !o_app_rd_valid && !o_app_wr_valid)
        else $error("unreachable address not refused");

    // TCP link never reaches 0x0090-0x009F of the 0x0080 block; others never the gateway block
    iface_block_a : assert property (
        fire && ((i_req_iface != 2'h2 && i_req_addr[15:8] == 8'hA0)
                 || (i_req_iface == 2'h1 && i_req_addr[15:4] == 12'h009))
        |=> o_rsp_exc == 8'h02)
        else $error("interface range not enforced");

    // gated write without login fails and never reaches the application
    login_gate_a : assert property (
        fire && allowed && i_req_write && gated && !i_login_ok && (writable || sig_slot)
        |=> o_rsp_valid && o_rsp_exc == 8'h04 ##1 !o_app_wr_valid)
        else $error("gated write let through");

    // an ordinary read asks the application, answer follows the ack
    app_read_a : assert property (
        fire && allowed && !sig_slot && !i_req_write
        |=> o_app_rd_valid && !o_rsp_valid && o_app_addr == $past(i_req_addr))
        else $error("read not passed to application");

    // the packed word is returned one cycle after the ack
    read_data_a : assert property (
        o_app_rd_valid && i_app_ack
        |=> o_rsp_valid && o_rsp_rdata == $past(pack_reg) && o_req_ready)
        else $error("read data not returned");

    // an answer is a single-cycle pulse unless a new request is taken with it
    rsp_pulse_a : assert property (
        o_rsp_valid && !fire |=> !o_rsp_valid)
        else $error("answer held longer than one cycle");

    // nothing moves the signature except its own accesses
    sig_hold_a : assert property (
        !(fire && sig_slot) |=> $stable(o_signature))
        else $error("signature changed without access");

endmodule

// ===== sim/mmr_app_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// application store behind the register map
// ----------------------------------------
module mmr_app_model (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rd_valid,
    input  wire logic        i_wr_valid,
    input  wire logic [3:0]  i_delay,
    input  wire logic [31:0] i_word,
    input  wire logic [2:0]  i_fmt,
    input  wire logic        i_sel_hi,
    output logic             o_ack,
    output logic [31:0]      o_rdata,
    output logic [2:0]       o_fmt,
    output logic             o_sel_hi
);
    logic [3:0] wait_reg = 4'h0; // cycles the request has waited

    initial begin
        o_ack    = 1'b0;
        o_rdata  = 32'h0000_0000;
        o_fmt    = 3'h0;
        o_sel_hi = 1'b0;
    end

    // one ack pulse after the set delay; data means nothing outside it,
    // so it toggles every cycle to expose a mapper that samples too late
    always @(posedge i_ref_clk) begin
        if ((i_rd_valid || i_wr_valid) && !o_ack && wait_reg >= i_delay) begin
            o_ack    <= 1'b1;
            o_rdata  <= i_word;
            o_fmt    <= i_fmt;
            o_sel_hi <= i_sel_hi;
            wait_reg <= 4'h0;
        end else begin
            o_ack    <= 1'b0;
            o_rdata  <= ~o_rdata;
            o_fmt    <= ~o_fmt;
            o_sel_hi <= ~o_sel_hi;
            wait_reg <= (i_rd_valid || i_wr_valid) ? wait_reg + 4'h1 : 4'h0;
        end
    end
endmodule

// ===== sim/test_modbus_register_data_mapper.sv
`timescale 1ns/1ps

module test_modbus_register_data_mapper;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic        clk       = 1'b0;
    logic        arst_n    = 1'b0;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic [15:0] req_addr  = 16'h0000;
    logic [15:0] req_wdata = 16'h0000;
    logic [1:0]  req_iface = 2'h0;
    logic        login_ok  = 1'b0;
    logic [3:0]  app_delay = 4'h0;
    logic [31:0] app_word  = 32'h0000_0000;
    logic [2:0]  app_fmt   = 3'h1;
    logic        app_sel   = 1'b0;
    logic        req_ready;
    logic        rsp_valid;
    logic [15:0] rsp_rdata;
    logic [7:0]  rsp_exc;
    logic        rd_valid;
    logic        wr_valid;
    logic [15:0] app_addr;
    logic [15:0] app_wdata;
    logic        ack;
    logic [31:0] a_rdata;
    logic [2:0]  a_fmt;
    logic        a_sel;
    logic [15:0] signature;
    int          err_total       = 0;
    int          samples_checked = 0;

    always #10 clk = ~clk;

    mmr_mapper DUT (.i_ref_clk(clk), .i_arst_n(arst_n), .i_req_valid(req_valid),
        .o_req_ready(req_ready), .i_req_write(req_write), .i_req_addr(req_addr),
        .i_req_wdata(req_wdata), .i_req_iface(req_iface), .i_login_ok(login_ok),
        .o_rsp_valid(rsp_valid), .o_rsp_rdata(rsp_rdata), .o_rsp_exc(rsp_exc),
        .o_app_rd_valid(rd_valid), .o_app_wr_valid(wr_valid), .o_app_addr(app_addr),
        .o_app_wdata(app_wdata), .i_app_ack(ack), .i_app_rdata(a_rdata), .i_app_fmt(a_fmt),
        .i_app_sel_hi(a_sel), .o_signature(signature));

    mmr_app_model u_app (.i_ref_clk(clk), .i_rd_valid(rd_valid), .i_wr_valid(wr_valid),
        .i_delay(app_delay), .i_word(app_word), .i_fmt(app_fmt), .i_sel_hi(app_sel),
        .o_ack(ack), .o_rdata(a_rdata), .o_fmt(a_fmt), .o_sel_hi(a_sel));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // present a request and hold it until the edge that takes it
    task automatic send(input logic wr, input logic [15:0] a, input logic [15:0] wd,
                        input logic [1:0] ifc, input logic lg);
        int n;
        n = 0;
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr  <= a;
        req_wdata <= wd;
        req_iface <= ifc;
        login_ok  <= lg;
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        req_valid <= 1'b0;
    endtask

    // bounded wait for the one-cycle answer pulse
    task automatic get(input logic [7:0] e, input logic [15:0] rd);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 50);
        chk({15'h0000, rsp_valid}, 16'h0001);
        chk({8'h00, rsp_exc}, {8'h00, e});
        chk(rsp_rdata, rd);
    endtask

    task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] wd,
                       input logic [1:0] ifc, input logic lg, input logic [7:0] e,
                       input logic [15:0] rd);
        send(wr, a, wd, ifc, lg);
        get(e, rd);
    endtask

    // reads that succeed return the app word, everything else returns zero
    task automatic rg(input logic [15:0] a, input logic [1:0] ifc, input logic wr,
                      input logic lg, input logic [7:0] e);
        acc(wr, a, 16'h00C3, ifc, lg, e, (e == 8'h00 && !wr) ? 16'h5A5A : 16'h0000);
    endtask

    task automatic fmt1(input logic [2:0] f, input logic [31:0] w, input logic s,
                        input logic [15:0] e);
        app_fmt  <= f;
        app_word <= w;
        app_sel  <= s;
        acc(1'b0, 16'h3401, 16'h0000, 2'h0, 1'b0, 8'h00, e);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk({15'h0000, req_ready}, 16'h0001);
        chk({14'h0000, rsp_valid, rd_valid | wr_valid}, 16'h0000);
        chk(signature, 16'h0000);
        $display("test reset done");
    endtask

    // signature written, read from another slot, polled, wrapped, refused
    task automatic t_sig();
        acc(1'b0, 16'h0000, 16'h0000, 2'h0, 1'b0, 8'h00, 16'h0000);
        chk(signature, 16'hFFFF);
        acc(1'b1, 16'h0000, 16'h1234, 2'h0, 1'b0, 8'h00, 16'h0000);
        acc(1'b0, 16'h0020, 16'h0000, 2'h1, 1'b0, 8'h00, 16'h1234);
        acc(1'b0, 16'h1400, 16'h0000, 2'h2, 1'b0, 8'h00, 16'h1233);
        chk(signature, 16'h1232);
        acc(1'b1, 16'hA000, 16'h0000, 2'h2, 1'b0, 8'h00, 16'h0000);
        acc(1'b0, 16'h0080, 16'h0000, 2'h1, 1'b0, 8'h02, 16'h0000);
        chk(signature, 16'h0000);
        $display("test signature done");
    endtask

    // write then read with no gap; the echo proves it is our answer
    task automatic t_b2b();
        // valid stays up across both requests; only the direction changes
        req_valid <= 1'b1;
        req_write <= 1'b1;
        req_addr  <= 16'h0200;
        req_wdata <= 16'h5A01;
        req_iface <= 2'h0;
        login_ok  <= 1'b0;
        @(posedge clk);
        chk({15'h0000, req_ready}, 16'h0001);
        req_write <= 1'b0;
        @(posedge clk);
        chk({15'h0000, req_ready}, 16'h0001);
        chk({15'h0000, rsp_valid}, 16'h0001);
        req_valid <= 1'b0;
        get(8'h00, 16'h5A01);
        chk(signature, 16'h5A00);
        $display("test back to back done");
    endtask

    task automatic t_fmt();
        app_delay <= 4'h0;
        fmt1(mmr_pkg::MMR_FMT_U8PAIR, 32'h1234_ABCD, 1'b0, 16'hABCD);
        fmt1(mmr_pkg::MMR_FMT_U16, 32'h1234_BEEF, 1'b1, 16'hBEEF);
        fmt1(mmr_pkg::MMR_FMT_U32, 32'h8765_4321, 1'b1, 16'h8765);
        fmt1(mmr_pkg::MMR_FMT_U32, 32'h8765_4321, 1'b0, 16'h4321);
        fmt1(mmr_pkg::MMR_FMT_F32, 32'hC148_0000, 1'b1, 16'hC148);
        fmt1(mmr_pkg::MMR_FMT_F32, 32'hC148_0000, 1'b0, 16'h0000);
        fmt1(mmr_pkg::MMR_FMT_UTF8, 32'hAC82_E231, 1'b0, 16'hE231);
        fmt1(mmr_pkg::MMR_FMT_UTF8, 32'hAC82_E231, 1'b1, 16'hAC82);
        fmt1(mmr_pkg::MMR_FMT_UTF8, 32'h4400_0031, 1'b1, 16'h0000);
        fmt1(mmr_pkg::MMR_FMT_ASCII, 32'h0000_6B4F, 1'b0, 16'h6B4F);
        fmt1(mmr_pkg::MMR_FMT_ASCII, 32'h4243_0041, 1'b1, 16'h0000);
        $display("test formats done");
    endtask

    // slow application: the mapper must stall and keep the request out
    task automatic t_slow();
        app_fmt   <= mmr_pkg::MMR_FMT_U16;
        app_word  <= 32'h0000_5A5A;
        app_delay <= 4'h6;
        send(1'b0, 16'h0201, 16'h0000, 2'h1, 1'b0);
        repeat (2) @(posedge clk);
        chk({14'h0000, req_ready, rd_valid}, 16'h0001);
        chk(app_addr, 16'h0201);
        get(8'h00, 16'h5A5A);
        // write data must stand at the application while it is asked
        send(1'b1, 16'h0301, 16'h00C3, 2'h0, 1'b0);
        @(posedge clk);
        chk({15'h0000, wr_valid}, 16'h0001);
        chk(app_wdata, 16'h00C3);
        get(8'h00, 16'h0000);
        app_delay <= 4'h3;
        $display("test slow app done");
    endtask

    task automatic t_rng();
        rg(16'h0068, 2'h1, 1'b0, 1'b0, 8'h00);
        rg(16'h0069, 2'h0, 1'b0, 1'b0, 8'h02);
        rg(16'h00AA, 2'h0, 1'b0, 1'b0, 8'h00);
        rg(16'h0081, 2'h1, 1'b0, 1'b0, 8'h02);
        rg(16'h0205, 2'h2, 1'b0, 1'b0, 8'h00);
        rg(16'h0208, 2'h1, 1'b0, 1'b0, 8'h00);
        rg(16'h0209, 2'h0, 1'b0, 1'b0, 8'h02);
        rg(16'h0301, 2'h2, 1'b1, 1'b0, 8'h00);
        rg(16'h8501, 2'h1, 1'b1, 1'b0, 8'h00);
        rg(16'h1503, 2'h2, 1'b1, 1'b0, 8'h04);
        rg(16'h1503, 2'h0, 1'b1, 1'b0, 8'h00);
        rg(16'h0309, 2'h2, 1'b1, 1'b0, 8'h04);
        rg(16'h0309, 2'h2, 1'b1, 1'b1, 8'h00);
        rg(16'h4122, 2'h2, 1'b1, 1'b0, 8'h04);
        rg(16'hA111, 2'h2, 1'b1, 1'b0, 8'h04);
        rg(16'hA111, 2'h1, 1'b1, 1'b0, 8'h00);
        rg(16'h1014, 2'h0, 1'b0, 1'b0, 8'h00);
        rg(16'h1015, 2'h0, 1'b0, 1'b0, 8'h02);
        rg(16'h8408, 2'h1, 1'b0, 1'b0, 8'h00);
        rg(16'h2210, 2'h2, 1'b0, 1'b0, 8'h00);
        rg(16'h2211, 2'h2, 1'b0, 1'b0, 8'h02);
        rg(16'hA016, 2'h2, 1'b0, 1'b0, 8'h00);
        rg(16'hA016, 2'h0, 1'b0, 1'b0, 8'h02);
        rg(16'h0404, 2'h0, 1'b0, 1'b0, 8'h02);
        rg(16'h9404, 2'h0, 1'b0, 1'b0, 8'h02);
        rg(16'h9122, 2'h2, 1'b1, 1'b0, 8'h02);
        rg(16'h0201, 2'h0, 1'b1, 1'b0, 8'h02);
        rg(16'h0201, 2'h3, 1'b0, 1'b0, 8'h02);
        $display("test ranges done");
    endtask

    // ----------------------------------------
    // verdict, main sequence and watchdog
    // ----------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        t_reset();
        arst_n <= 1'b1;
        @(posedge clk);
        t_sig();
        t_b2b();
        t_fmt();
        t_slow();
        t_rng();
        test_done();
    end

    // about 50 accesses of at most a dozen cycles each fit well inside this
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        test_done();
    end
endmodule
